// ==== pkg/tsu_pkg.sv ====
package tsu_pkg;
    // Clock and timing
    localparam int CLK_FREQ_HZ            = 200_000_000;
    localparam int MS_PER_S               = 1000;
    localparam int SNTP_REPLY_TIMEOUT_MS  = 500;
    localparam int SNTP_REPLY_TIMEOUT_CYC = SNTP_REPLY_TIMEOUT_MS * (CLK_FREQ_HZ / MS_PER_S);
    localparam int TC_LOSS_TIME_S         = 60;
    localparam int DST_SHIFT_S            = 3600;

    // Calendar arithmetic
    localparam int SEC_W        = 25;
    localparam int YEAR_W       = 16;
    localparam int SEC_PER_MIN  = 60;
    localparam int SEC_PER_HOUR = 3600;
    localparam int SEC_PER_DAY  = 86400;
    localparam int DAYS_YEAR    = 365;
    localparam int DAYS_LEAP    = 366;
    localparam int YEAR_BASE    = 2000;
    localparam int DEC_BASE     = 10;

    // Time code
    localparam int         TC_CMD_COUNT      = 18;
    localparam int         TC_FMT_W          = 3;
    localparam logic [2:0] TC_FMT_YEAR_FIRST = 3'h4;
    localparam int         TC_FMT_NO_CF_BIT  = 1;
    localparam int         TC_LOSS_W         = 7;

    // Network time
    localparam int SRV_COUNT  = 2;
    localparam int SRV_ADDR_W = 32;
    localparam int POLL_W     = 6;
    localparam logic [POLL_W-1:0] SNTP_POLL_IVL_S [4] = '{6'h3c, 6'h1e, 6'h14, 6'h0f};
    localparam logic [7:0]         STRATUM_GOOD = 8'h02;
    localparam logic [7:0]         STRATUM_SUFF = 8'h04;
    localparam logic signed [7:0]  PREC_GOOD    = -8'sd17;
    localparam logic signed [7:0]  PREC_SUFF    = -8'sd12;
    localparam logic [15:0]        DELAY_GOOD_US = 16'h03e8;
    localparam logic [15:0]        DELAY_SUFF_US = 16'h2710;

    typedef enum logic [1:0] {TSU_SRC_NONE, TSU_SRC_TIMECODE, TSU_SRC_SNTP} tsu_src_type;
    typedef enum logic [1:0] {TSU_Q_GOOD, TSU_Q_SUFFICIENT, TSU_Q_BAD} tsu_quality_type;

    typedef struct packed {
        logic [YEAR_W-1:0] year;
        logic [SEC_W-1:0]  sec;
    } tsu_time_type;

    typedef struct packed {
        logic [7:0]              sec_bcd;
        logic [7:0]              min_bcd;
        logic [7:0]              hour_bcd;
        logic [11:0]             day_bcd;
        logic [7:0]              year_bcd;
        logic [TC_CMD_COUNT-1:0] cmd;
    } tsu_tc_frame_type;

    typedef struct packed {
        logic              srv;
        tsu_time_type      stamp;
        logic [7:0]        stratum;
        logic signed [7:0] precision;
        logic [15:0]       delay_us;
    } tsu_sntp_reply_type;
endpackage

// ==== core/tsu_tc_decode.sv ====
`timescale 1ns/1ps
module tsu_tc_decode
    import tsu_pkg::*;
(
    input  wire tsu_tc_frame_type        frame_i,
    input  wire logic [TC_FMT_W-1:0]     format_i,
    input  wire logic [YEAR_W-1:0]       manual_year_i,
    output tsu_time_type                 stamp_o,
    output logic [TC_CMD_COUNT-1:0]      cmd_o
);
    function automatic int bcd2(input logic [7:0] b);
        return int'(b[7:4]) * DEC_BASE + int'(b[3:0]);
    endfunction

    int day;

    // Field conversion; a day of zero is invalid code and wraps harmlessly
    always_comb begin
        day = int'(frame_i.day_bcd[11:8]) * DEC_BASE * DEC_BASE + bcd2(frame_i.day_bcd[7:0]);
        stamp_o.sec = SEC_W'((day - 1) * SEC_PER_DAY + bcd2(frame_i.hour_bcd) * SEC_PER_HOUR
                      + bcd2(frame_i.min_bcd) * SEC_PER_MIN + bcd2(frame_i.sec_bcd));
        // Lower variants carry no year, so the manual year stands in
        if (format_i >= TC_FMT_YEAR_FIRST) begin
            stamp_o.year = YEAR_W'(YEAR_BASE + bcd2(frame_i.year_bcd));
        end else begin
            stamp_o.year = manual_year_i;
        end
        // Only variants with a control field carry commands
        cmd_o = format_i[TC_FMT_NO_CF_BIT] ? '0 : frame_i.cmd;
    end
endmodule

// ==== core/tsu_time_sync_unit.sv ====
`timescale 1ns/1ps
module tsu_time_sync_unit
    import tsu_pkg::*;
#(
    parameter int TICKS_PER_SEC = CLK_FREQ_HZ,
    parameter int REPLY_TIMEOUT = SNTP_REPLY_TIMEOUT_CYC
)(
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_n_i,
    input  wire tsu_src_type                          time_source_select_i,
    input  wire logic                                 manual_wr_i,
    input  wire tsu_time_type                         manual_time_i,
    input  wire logic [YEAR_W-1:0]                    manual_year_i,
    input  wire logic signed [17:0]                   tz_offset_i,
    input  wire logic                                 dst_enable_i,
    input  wire logic [SEC_W-1:0]                     dst_start_i,
    input  wire logic [SEC_W-1:0]                     dst_end_i,
    input  wire logic                                 tc_enable_i,
    input  wire logic [TC_FMT_W-1:0]                  tc_format_i,
    input  wire logic                                 tc_frame_valid_i,
    input  wire tsu_tc_frame_type                     tc_frame_i,
    input  wire logic [SRV_COUNT-1:0]                 srv_active_i,
    input  wire logic [SRV_COUNT-1:0][SRV_ADDR_W-1:0] srv_addr_i,
    input  wire logic [1:0]                           poll_rate_i,
    input  wire logic                                 sntp_reply_valid_i,
    input  wire tsu_sntp_reply_type                   sntp_reply_i,
    output tsu_time_type                              utc_time_o,
    output tsu_time_type                              local_time_o,
    output logic                                      tc_active_o,
    output logic                                      tc_loss_event_o,
    output logic [TC_CMD_COUNT-1:0]                   timecode_command_flag_o,
    output logic                                      sntp_req_o,
    output logic                                      sntp_req_srv_o,
    output logic [SRV_ADDR_W-1:0]                     sntp_req_addr_o,
    output logic                                      sntp_srv_in_use_o,
    output logic                                      sntp_pri_failed_o,
    output tsu_quality_type                           srv_quality_o,
    output tsu_quality_type                           net_quality_o
);
    localparam int SUB_W = $clog2(TICKS_PER_SEC);
    localparam int TMO_W = $clog2(REPLY_TIMEOUT + 1);

    typedef enum {ST_IDLE, ST_WAIT_PRI, ST_WAIT_SEC} tsu_sntp_state_type;

    function automatic logic [SEC_W-1:0] year_len(input logic [YEAR_W-1:0] y);
        // Four-year leap rule only; correct through 2099
        return (y[1:0] == 2'h0) ? SEC_W'(DAYS_LEAP * SEC_PER_DAY) : SEC_W'(DAYS_YEAR * SEC_PER_DAY);
    endfunction

    tsu_time_type                 dec_stamp;
    logic [TC_CMD_COUNT-1:0]      dec_cmd;

    tsu_tc_decode u_decode (
        .frame_i       (tc_frame_i),
        .format_i      (tc_format_i),
        .manual_year_i (manual_year_i),
        .stamp_o       (dec_stamp),
        .cmd_o         (dec_cmd)
    );

    // Source qualification
    logic                 tc_sel;
    logic                 sntp_sel;
    logic                 tc_load;
    logic                 sntp_load;
    logic                 man_load;
    logic [SRV_COUNT-1:0] usable;
    logic                 sec_tick;
    tsu_sntp_state_type   state;
    logic [SUB_W-1:0]     sub_cnt;

    assign tc_sel   = (time_source_select_i == TSU_SRC_TIMECODE) && tc_enable_i;
    assign sntp_sel = (time_source_select_i == TSU_SRC_SNTP);
    assign tc_load  = tc_sel && tc_frame_valid_i;
    assign man_load = (time_source_select_i == TSU_SRC_NONE) && manual_wr_i;
    // A reply counts only from the server being waited on
    assign sntp_load = sntp_sel && sntp_reply_valid_i
                       && ((state == ST_WAIT_PRI && !sntp_reply_i.srv)
                       || (state == ST_WAIT_SEC && sntp_reply_i.srv));
    assign sec_tick = (sub_cnt == SUB_W'(TICKS_PER_SEC - 1));

    // Server is usable only with a nonzero address and its active flag
    for (genvar g = 0; g < SRV_COUNT; g++) begin : g_usable
        assign usable[g] = srv_active_i[g] && (srv_addr_i[g] != '0);
    end

    // Time base: UTC seconds of year plus year, loaded by the one selected source
    tsu_time_type     utc;
    tsu_time_type     next_utc;
    logic [SUB_W-1:0] next_sub;

    always_comb begin
        next_utc = utc;
        next_sub = sub_cnt + SUB_W'(1);
        if (sec_tick) begin
            next_sub = '0;
            if (utc.sec == year_len(utc.year) - SEC_W'(1)) begin
                next_utc.year = utc.year + YEAR_W'(1);
                next_utc.sec  = '0;
            end else begin
                next_utc.sec = utc.sec + SEC_W'(1);
            end
        end
        // A frame marks the start of its second, so the phase restarts too
        if (tc_load) begin
            next_utc = dec_stamp;
            next_sub = '0;
        end else if (sntp_load) begin
            next_utc = sntp_reply_i.stamp;
            next_sub = '0;
        end else if (man_load) begin
            next_utc = manual_time_i;
            next_sub = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            utc     <= '{year: YEAR_W'(YEAR_BASE), sec: '0};
            sub_cnt <= '0;
        end else begin
            utc     <= next_utc;
            sub_cnt <= next_sub;
        end
    end

    // Time-code status, loss timer and command flags
    logic                    tc_active;
    logic                    tc_event;
    logic [TC_LOSS_W-1:0]    loss_cnt;
    logic [TC_CMD_COUNT-1:0] cmd;
    logic                    next_tc_active;
    logic                    next_tc_event;
    logic [TC_LOSS_W-1:0]    next_loss_cnt;
    logic [TC_CMD_COUNT-1:0] next_cmd;

    always_comb begin
        next_tc_active = tc_active;
        next_tc_event  = 1'b0;
        next_loss_cnt  = loss_cnt;
        next_cmd       = cmd;
        if (!tc_sel) begin
            next_tc_active = 1'b0;
            next_loss_cnt  = '0;
            next_cmd       = '0;
        end else if (tc_frame_valid_i) begin
            next_tc_active = 1'b1;
            next_loss_cnt  = '0;
            next_cmd       = dec_cmd;
        end else if (sec_tick && tc_active) begin
            // Counter passes the limit only after more than the full loss time
            if (loss_cnt == TC_LOSS_W'(TC_LOSS_TIME_S)) begin
                next_tc_active = 1'b0;
                next_tc_event  = 1'b1;
                next_loss_cnt  = '0;
                next_cmd       = '0;
            end else begin
                next_loss_cnt = loss_cnt + TC_LOSS_W'(1);
            end
        end
    end

    // Command flags feed no event path; users must gate them to record them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tc_active <= 1'b0;
            tc_event  <= 1'b0;
            loss_cnt  <= '0;
            cmd       <= '0;
        end else begin
            tc_active <= next_tc_active;
            tc_event  <= next_tc_event;
            loss_cnt  <= next_loss_cnt;
            cmd       <= next_cmd;
        end
    end

    // Network poll scheduler with primary-first failover
    tsu_sntp_state_type  next_state;
    logic [POLL_W-1:0]   poll_cnt;
    logic [POLL_W-1:0]   next_poll_cnt;
    logic [TMO_W-1:0]    wait_cnt;
    logic [TMO_W-1:0]    next_wait_cnt;
    logic                req;
    logic                req_srv;
    logic                next_req;
    logic                next_req_srv;
    logic                in_use;
    logic                next_in_use;
    logic                pri_failed;
    logic                next_pri_failed;
    logic                poll_go;
    logic                timeout;
    tsu_quality_type     srv_q;
    tsu_quality_type     net_q;
    tsu_quality_type     next_srv_q;
    tsu_quality_type     next_net_q;

    assign timeout = (wait_cnt == TMO_W'(REPLY_TIMEOUT - 1));

    always_comb begin
        next_state      = state;
        next_poll_cnt   = poll_cnt;
        next_wait_cnt   = wait_cnt + TMO_W'(1);
        next_req        = 1'b0;
        next_req_srv    = req_srv;
        next_in_use     = in_use;
        next_pri_failed = pri_failed;
        next_srv_q      = srv_q;
        next_net_q      = net_q;
        poll_go         = 1'b0;
        if (sec_tick) begin
            if (poll_cnt + POLL_W'(1) >= SNTP_POLL_IVL_S[poll_rate_i]) begin
                next_poll_cnt = '0;
                poll_go       = 1'b1;
            end else begin
                next_poll_cnt = poll_cnt + POLL_W'(1);
            end
        end
        if (!sntp_sel) begin
            next_state    = ST_IDLE;
            next_poll_cnt = '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Every poll tries server one first when it is usable, which gives the way back
                    if (poll_go && usable[0]) begin
                        next_state    = ST_WAIT_PRI;
                        next_req      = 1'b1;
                        next_req_srv  = 1'b0;
                        next_wait_cnt = '0;
                    end else if (poll_go && usable[1]) begin
                        next_state    = ST_WAIT_SEC;
                        next_req      = 1'b1;
                        next_req_srv  = 1'b1;
                        next_wait_cnt = '0;
                    end
                end
                ST_WAIT_PRI: begin
                    if (sntp_load) begin
                        next_state      = ST_IDLE;
                        next_in_use     = 1'b0;
                        next_pri_failed = 1'b0;
                    end else if (timeout) begin
                        next_pri_failed = 1'b1;
                        next_state      = usable[1] ? ST_WAIT_SEC : ST_IDLE;
                        next_req        = usable[1];
                        next_req_srv    = 1'b1;
                        next_wait_cnt   = '0;
                    end
                end
                ST_WAIT_SEC: begin
                    if (sntp_load) begin
                        next_state  = ST_IDLE;
                        next_in_use = 1'b1;
                    end else if (timeout) begin
                        next_state = ST_IDLE;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
        // Grades from the reply that was taken
        if (sntp_load) begin
            if (sntp_reply_i.stratum <= STRATUM_GOOD && sntp_reply_i.precision <= PREC_GOOD) begin
                next_srv_q = TSU_Q_GOOD;
            end else if (sntp_reply_i.stratum <= STRATUM_SUFF
                         && sntp_reply_i.precision <= PREC_SUFF) begin
                next_srv_q = TSU_Q_SUFFICIENT;
            end else begin
                next_srv_q = TSU_Q_BAD;
            end
            if (sntp_reply_i.delay_us <= DELAY_GOOD_US) begin
                next_net_q = TSU_Q_GOOD;
            end else if (sntp_reply_i.delay_us <= DELAY_SUFF_US) begin
                next_net_q = TSU_Q_SUFFICIENT;
            end else begin
                next_net_q = TSU_Q_BAD;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= ST_IDLE;
            poll_cnt   <= '0;
            wait_cnt   <= '0;
            req        <= 1'b0;
            req_srv    <= 1'b0;
            in_use     <= 1'b0;
            pri_failed <= 1'b0;
            srv_q      <= TSU_Q_BAD;
            net_q      <= TSU_Q_BAD;
        end else begin
            state      <= next_state;
            poll_cnt   <= next_poll_cnt;
            wait_cnt   <= next_wait_cnt;
            req        <= next_req;
            req_srv    <= next_req_srv;
            in_use     <= next_in_use;
            pri_failed <= next_pri_failed;
            srv_q      <= next_srv_q;
            net_q      <= next_net_q;
        end
    end

    // Local time for display: UTC plus zone plus optional daylight shift
    tsu_time_type              local_t;
    tsu_time_type              next_local;
    logic signed [SEC_W+1:0]   lsum;
    logic                      dst_on;
    logic [YEAR_W-1:0]         y_prev;

    always_comb begin
        y_prev = utc.year - YEAR_W'(1);
        dst_on = dst_enable_i && (utc.sec >= dst_start_i) && (utc.sec < dst_end_i);
        lsum   = $signed({2'b00, utc.sec}) + (SEC_W+2)'(tz_offset_i)
                 + (dst_on ? (SEC_W+2)'(DST_SHIFT_S) : '0);
        next_local = '{year: utc.year, sec: lsum[SEC_W-1:0]};
        if (lsum < 0) begin
            next_local.year = y_prev;
            next_local.sec  = SEC_W'(lsum + $signed({2'b00, year_len(y_prev)}));
        end else if (lsum >= $signed({2'b00, year_len(utc.year)})) begin
            next_local.year = utc.year + YEAR_W'(1);
            next_local.sec  = SEC_W'(lsum - $signed({2'b00, year_len(utc.year)}));
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            local_t <= '{year: YEAR_W'(YEAR_BASE), sec: '0};
        end else begin
            local_t <= next_local;
        end
    end

    assign utc_time_o              = utc;
    assign local_time_o            = local_t;
    assign tc_active_o             = tc_active;
    assign tc_loss_event_o         = tc_event;
    assign timecode_command_flag_o = cmd;
    assign sntp_req_o              = req;
    assign sntp_req_srv_o          = req_srv;
    assign sntp_req_addr_o         = srv_addr_i[req_srv];
    assign sntp_srv_in_use_o       = in_use;
    assign sntp_pri_failed_o       = pri_failed;
    assign srv_quality_o           = srv_q;
    assign net_quality_o           = net_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_tc_needs_enable: assert property (
        $changed(tc_active_o) && tc_active_o |-> $past(tc_sel)) else $error("tc active unselected");
    a_manual_free: assert property (
        man_load |=> utc_time_o == $past(manual_time_i)) else $error("manual time lost");
    a_tc_resync: assert property (
        tc_load |=> utc_time_o == $past(dec_stamp) && tc_active_o) else $error("frame not applied");
    a_year_manual: assert property (
        tc_load && tc_format_i < TC_FMT_YEAR_FIRST |=> utc_time_o.year == $past(manual_year_i))
        else $error("manual year not used");
    a_tc_loss_event: assert property (
        tc_active && tc_sel && sec_tick && !tc_frame_valid_i
        && loss_cnt == TC_LOSS_W'(TC_LOSS_TIME_S)
        |=> !tc_active_o && tc_loss_event_o ##1 !tc_loss_event_o) else $error("loss not flagged");
    a_cmd_follow: assert property (
        tc_load |=> timecode_command_flag_o == $past(dec_cmd)) else $error("command not shown");
    a_req_usable: assert property (
        sntp_req_o |-> usable[sntp_req_srv_o]) else $error("request to unusable server");
    a_pri_first: assert property (
        state == ST_IDLE && sntp_sel && poll_go && usable[0]
        |=> sntp_req_o && !sntp_req_srv_o) else $error("server one not tried first");
    a_failover: assert property (
        state == ST_WAIT_PRI && sntp_sel && timeout && !sntp_load && usable[1]
        |=> sntp_req_o && sntp_req_srv_o && sntp_pri_failed_o) else $error("no failover");
    a_local_plain: assert property (
        tz_offset_i == '0 && !dst_enable_i |=> local_time_o == $past(utc_time_o))
        else $error("local differs from utc");

    c_failover: cover property (state == ST_WAIT_SEC && sntp_load);
    c_recover: cover property (sntp_pri_failed_o && sntp_load && state == ST_WAIT_PRI);
    c_tc_loss: cover property (tc_loss_event_o);
    c_manual: cover property (man_load);
endmodule

// ==== sim/tsu_sntp_server_model.sv ====
`timescale 1ns/1ps
module tsu_sntp_server_model
    import tsu_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          req_i,
    input  wire logic          req_srv_i,
    input  wire logic          mute_pri_i,
    input  wire tsu_time_type  stamp_i,
    output logic               reply_valid_o,
    output tsu_sntp_reply_type reply_o
);
    logic [2:0]         cnt = 3'h0;
    logic               srv = 1'b0;
    tsu_sntp_reply_type ans;
    // Answer a few cycles after each request; a muted first server stays silent
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 3'h0;
        end else if (req_i && (req_srv_i || !mute_pri_i)) begin
            cnt <= 3'h3;
            srv <= req_srv_i;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    // Stratum and precision ride with every stamp; fields flip while idle
    // Server two answers with poorer figures so the middle grades get exercised
    assign ans = {srv, stamp_i, srv ? 8'h03 : 8'h01, srv ? -8'sh0e : -8'sh14,
                  srv ? 16'h1388 : 16'h0064};
    assign reply_valid_o = (cnt == 3'h1);
    assign reply_o = reply_valid_o ? ans : ~ans;
endmodule

// ==== sim/tb_tsu_time_sync_unit.sv ====
`timescale 1ns/1ps
module tb_tsu_time_sync_unit;
    import tsu_pkg::*;
    typedef struct packed {logic [24:0] sec; logic [17:0] tz; logic dst; logic [24:0] loc;} tsu_row_type;
    logic clk_i = 1'b0, rst_n_i = 1'b0, manual_wr_i = 1'b0, dst_enable_i = 1'b0;
    logic tc_enable_i = 1'b0, tc_frame_valid_i = 1'b0, mute_pri = 1'b0;
    tsu_src_type time_source_select_i = TSU_SRC_NONE;
    tsu_time_type manual_time_i = '0, stamp = {16'h07f8, 25'h0}, utc_time_o, local_time_o;
    logic signed [17:0] tz_offset_i = '0;
    logic [SEC_W-1:0] dst_start_i = '0, dst_end_i = 25'h3e8;
    logic [YEAR_W-1:0] manual_year_i = 16'h07ef;
    logic [2:0] tc_format_i = 3'h0;
    tsu_tc_frame_type tc_frame_i = {8'h05, 8'h00, 8'h00, 12'h001, 8'h25, 18'h20001};
    logic [1:0] srv_active_i = 2'h3, poll_rate_i = 2'h3;
    logic [1:0][31:0] srv_addr_i = {32'h0a000002, 32'h0a000001};
    logic sntp_reply_valid_i, tc_active_o, tc_loss_event_o, sntp_req_o, sntp_req_srv_o;
    logic sntp_srv_in_use_o, sntp_pri_failed_o;
    tsu_sntp_reply_type sntp_reply_i;
    logic [17:0] timecode_command_flag_o;
    logic [31:0] sntp_req_addr_o;
    tsu_quality_type srv_quality_o, net_quality_o;
    int errors = 0, num_checks = 0, n;
    // Manual write, offset, daylight flag, expected local second
    tsu_row_type rows [3] = '{{25'h64, 18'he10, 1'b0, 25'he74},
        {25'h1388, -18'she10, 1'b0, 25'h578}, {25'hc8, 18'h0, 1'b1, 25'hed8}};
    tsu_time_sync_unit #(.TICKS_PER_SEC(50), .REPLY_TIMEOUT(10)) tsu_time_sync_unit_inst (.*);
    tsu_sntp_server_model tsu_sntp_server_model_inst (.clk_i, .rst_n_i, .req_i(sntp_req_o),
        .req_srv_i(sntp_req_srv_o), .mute_pri_i(mute_pri), .stamp_i(stamp),
        .reply_valid_o(sntp_reply_valid_i), .reply_o(sntp_reply_i));
    always #2.5 clk_i = ~clk_i;
    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic chk(input string what, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Pulses are one cycle wide so the next edge never sees a stale strobe
    task automatic pulse(input bit frame);
        if (frame) tc_frame_valid_i = 1'b1;
        else manual_wr_i = 1'b1;
        tick(1);
        {tc_frame_valid_i, manual_wr_i} = 2'h0;
        tick(2);
    endtask
    task automatic wait_req;
        n = 0;
        while (!sntp_req_o && n < 1000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Whole run needs about 6100 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end
    initial begin
        tick(20);
        rst_n_i = 1'b1;
        tick(2);
        chk("reset", {utc_time_o, srv_quality_o, tc_active_o}, {16'h07d0, 25'h0, 3'h4});
        foreach (rows[i]) begin
            manual_time_i = {16'h07d0, rows[i].sec};
            {tz_offset_i, dst_enable_i} = {rows[i].tz, rows[i].dst};
            pulse(1'b0);
            chk("utc", utc_time_o, manual_time_i);
            chk("local", local_time_o.sec, rows[i].loc);
        end
        $display("test manual done");
        // The generator sends plain time here, so zone and daylight shift stay off
        {tz_offset_i, dst_enable_i} = '0;
        time_source_select_i = TSU_SRC_TIMECODE;
        manual_time_i.sec = 25'h1000;
        pulse(1'b0);
        chk("refused", utc_time_o.sec == 25'h1000, 1'b0);
        pulse(1'b1);
        chk("disabled", {tc_active_o, utc_time_o.year}, {1'b0, 16'h07d0});
        tc_enable_i = 1'b1;
        for (int f = 0; f < 8; f++) begin
            tc_format_i = f[2:0];
            pulse(1'b1);
            chk("year", utc_time_o.year, f > 3 ? 16'h07e9 : 16'h07ef);
            chk("sec", {tc_active_o, utc_time_o.sec}, 26'h2000005);
            chk("flags", timecode_command_flag_o, f[1] ? 18'h0 : 18'h20001);
            chk("local", local_time_o, {f > 3 ? 16'h07e9 : 16'h07ef, 25'h5});
        end
        // Counting starts two cycles after the last frame was taken
        n = 0;
        while (!tc_loss_event_o && n < 4000) begin
            tick(1);
            n++;
        end
        chk("loss time", n >= 2998 && n <= 3048, 1'b1);
        chk("inactive", {tc_active_o, timecode_command_flag_o}, 19'h0);
        pulse(1'b1);
        chk("active again", tc_active_o, 1'b1);
        $display("test timecode done");
        time_source_select_i = TSU_SRC_SNTP;
        for (int k = 0; k < 4; k++) begin
            mute_pri = (k == 1);
            srv_active_i[0] = (k != 3);
            wait_req();
            if (k == 0) chk("interval", n >= 690 && n <= 770, 1'b1);
            chk("first", {sntp_req_srv_o, sntp_req_addr_o}, {k == 3, srv_addr_i[k == 3]});
            if (k == 1) begin
                tick(1);
                wait_req();
                chk("failover", sntp_req_srv_o, 1'b1);
            end
            tick(6);
            chk("in use", sntp_srv_in_use_o, k[0]);
            if (k < 3) chk("failed", sntp_pri_failed_o, k == 1);
            chk("utc", utc_time_o.year, 16'h07f8);
            chk("quality", {srv_quality_o, net_quality_o}, k[0] ? 4'h5 : 4'h0);
        end
        $display("test sntp done");
        tally_and_finish();
    end
endmodule
